/* logic/pbw_cfg.svh */
// register offsets, field positions, reset values and fixed field codes
// for the secondary status and memory window register bank.
// included by name from the package and the bank module; definitions only.
`ifndef PBW_CFG_SVH
`define PBW_CFG_SVH

// byte offsets in configuration space
`define PBW_OFS_SEC_STATUS     8'h1e
`define PBW_OFS_MMIO_BASE      8'h20
`define PBW_OFS_MMIO_LIMIT     8'h22
`define PBW_OFS_PREFETCH_BASE  8'h24

// secondary status fixed bits: bit 5 set, bits 10:9 = 01b, all else zero
`define PBW_SSR_FIXED          16'h0220

// secondary status sticky flag positions
`define PBW_SSR_DATA_PAR_BIT   8
`define PBW_SSR_SIG_TABT_BIT   11
`define PBW_SSR_RCV_TABT_BIT   12
`define PBW_SSR_RCV_MABT_BIT   13
`define PBW_SSR_SIG_SERR_BIT   14
`define PBW_SSR_PAR_DET_BIT    15

// window registers: writable field and its read-only low nibble
`define PBW_WIN_FIELD_MSB      15
`define PBW_WIN_FIELD_LSB      4
`define PBW_MMIO_LOW_NIBBLE    4'h0
`define PBW_PREFETCH_LOW_NIBBLE 4'h1
`define PBW_WIN_FIELD_RESET    12'h000

// implied low twenty address bits of window base and limit, and the memory window upper word
`define PBW_BASE_LOW20         20'h00000
`define PBW_LIMIT_LOW20        20'hfffff
`define PBW_MMIO_UPPER32       32'h00000000

// bit 6 of the command register gates the data parity flag
`define PBW_CMD_PAR_RESP_BIT   6

`endif

/* logic/pbw_pkg.sv */
// types shared by the secondary status and memory window register bank.
// assumes pbw_cfg.svh is on the include path.
`include "pbw_cfg.svh"

package pbw_pkg;

	typedef logic [11:0] pbw_win_field_t;
	typedef logic [63:0] pbw_addr_t;
	typedef logic [15:0] pbw_half_t;

endpackage : pbw_pkg

/* logic/pbw_sync.sv */
// two-flop synchroniser for a group of asynchronous level inputs.
// assumes the inputs change slowly compared with clk.
`timescale 1ns/1ps
`default_nettype none

module pbw_sync #(
	parameter int          WIDTH     = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// asynchronous side
	input  wire logic [WIDTH-1:0] asyncIn,
	// clk side
	output var  logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// the first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q  <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule : pbw_sync

`default_nettype wire

/* logic/pbw_window_match.sv */
// inclusive address range compare for one forwarding window.
// assumes base and limit are already assembled to full 64-bit addresses.
`timescale 1ns/1ps
`default_nettype none

module pbw_window_match
	import pbw_pkg::*;
(
	// window
	input  wire pbw_addr_t windowBase,
	input  wire pbw_addr_t windowLimit,
	// transaction
	input  wire pbw_addr_t txnAddr,
	output var  logic      inWindow
);

	// a base above the limit gives an empty window, which disables it
	assign inWindow = (txnAddr >= windowBase) && (txnAddr <= windowLimit);

endmodule : pbw_window_match

`default_nettype wire

/* logic/pbw_bridge_regs.sv */
// secondary status and memory window register bank of a bridge's
// type 1 configuration header, with the forwarding window decode.
// assumes the configuration access port and event strobes run on clk;
// the two secondary error pins are asynchronous and are synchronised here.
//
// Functional notes
// - status bit 5 reads one, 66 MHz
// - status bits 4:0 and 6 read zero
// - status bit 7 reads zero, no fast b2b
// - bit 8 set: parity error with response enabled
// - status bits 10:9 read 01b, medium timing
// - bit 11 set on signalled target abort
// - bit 12 set on received target abort
// - bit 13 set on received master abort
// - bit 14 set when system error asserted, held until cleared
// - bit 15 set on any parity error
// - memory base bits 15:4 writable, address 31:20
// - memory base low twenty bits are zero
// - memory limit field, low twenty bits ones
// - memory base and limit bound forwarded range
// - memory base and limit nibble reads zero
// - prefetch base field writable, nibble reads one
// - prefetch window uses limit and upper words
// - prefetch limit low twenty bits are ones
// - prefetch base upper word gives bits 63:32
`timescale 1ns/1ps
`default_nettype none
`include "pbw_cfg.svh"

module pbw_bridge_regs
	import pbw_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// configuration access, byte address of the dword in cfgAddr[7:2]
	input  wire logic [7:0]  cfgAddr,
	input  wire logic [3:0]  cfgByteEn,
	input  wire logic        cfgWrite,
	input  wire logic        cfgRead,
	input  wire logic [31:0] cfgWrData,
	output var  logic [31:0] cfgRdData,
	output var  logic        cfgRdValid,
	// command register bit 6 held elsewhere
	input  wire logic        commandRegister,
	// secondary bus pins, asynchronous, active low
	input  wire logic        secondaryParityErrorN,
	input  wire logic        secondarySystemErrorN,
	// secondary interface events, one-cycle pulses on clk
	input  wire logic        sigTargetAbort,
	input  wire logic        rcvTargetAbort,
	input  wire logic        rcvMasterAbort,
	// prefetch registers held elsewhere
	input  wire pbw_half_t   prefetchWindowLimit,
	input  wire logic [31:0] prefetchBaseUpperWord,
	input  wire logic [31:0] prefetchLimitUpperWord,
	// memory transaction decode
	input  wire logic        txnValid,
	input  wire pbw_addr_t   txnAddr,
	output var  logic        mmioHit,
	output var  logic        prefetchHit
);

	// byte lanes of a half word, selected by two byte enables
	function automatic pbw_half_t laneMask(input logic [1:0] be);
		laneMask = {{8{be[1]}}, {8{be[0]}}};
	endfunction : laneMask

	// update of a 12-bit address field from a half word write
	function automatic pbw_win_field_t fieldWrite(
		input pbw_win_field_t cur,
		input pbw_half_t      data,
		input pbw_half_t      mask
	);
		pbw_win_field_t m;
		m = mask[`PBW_WIN_FIELD_MSB:`PBW_WIN_FIELD_LSB];
		fieldWrite = (data[`PBW_WIN_FIELD_MSB:`PBW_WIN_FIELD_LSB] & m) | (cur & ~m);
	endfunction : fieldWrite

	// sticky flag: a set in the same cycle as a clear wins
	function automatic logic flagNext(input logic cur, input logic set, input logic clr);
		flagNext = set | (cur & ~clr);
	endfunction : flagNext

	// synchronised pins
	logic [1:0] pinSync;
	logic       parityErr;
	logic       systemErr;

	pbw_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) u_pin_sync (
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn ({secondaryParityErrorN, secondarySystemErrorN}),
		.syncOut (pinSync)
	);

	assign parityErr = ~pinSync[1];
	assign systemErr = ~pinSync[0];

	// register state
	logic           dataParErr_q;
	logic           sigTgtAbt_q;
	logic           rcvTgtAbt_q;
	logic           rcvMstAbt_q;
	logic           sigSysErr_q;
	logic           parDetected_q;
	pbw_win_field_t mmioBase_q;
	pbw_win_field_t mmioLimit_q;
	pbw_win_field_t prefetchBase_q;

	// byte offsets held as typed constants so their dword bits can be sliced
	localparam logic [7:0] OfsSsr      = `PBW_OFS_SEC_STATUS;
	localparam logic [7:0] OfsMmio     = `PBW_OFS_MMIO_BASE;
	localparam logic [7:0] OfsPrefetch = `PBW_OFS_PREFETCH_BASE;

	// dword decode; status sits in the upper half of its dword
	wire logic selSsr      = cfgAddr[7:2] == OfsSsr[7:2];
	wire logic selMmio     = cfgAddr[7:2] == OfsMmio[7:2];
	wire logic selPrefetch = cfgAddr[7:2] == OfsPrefetch[7:2];

	wire pbw_half_t lowMask  = laneMask(cfgByteEn[1:0]);
	wire pbw_half_t highMask = laneMask(cfgByteEn[3:2]);
	wire pbw_half_t lowData  = cfgWrData[15:0];
	wire pbw_half_t highData = cfgWrData[31:16];

	// write-one-to-clear strobes; a zero bit leaves its flag alone
	wire pbw_half_t ssrClr = (cfgWrite && selSsr) ? (highData & highMask) : 16'h0000;

	// status assembled from fixed fields and sticky flags
	pbw_half_t ssrValue;
	always_comb begin
		ssrValue = `PBW_SSR_FIXED;
		ssrValue[`PBW_SSR_DATA_PAR_BIT] = dataParErr_q;
		ssrValue[`PBW_SSR_SIG_TABT_BIT] = sigTgtAbt_q;
		ssrValue[`PBW_SSR_RCV_TABT_BIT] = rcvTgtAbt_q;
		ssrValue[`PBW_SSR_RCV_MABT_BIT] = rcvMstAbt_q;
		ssrValue[`PBW_SSR_SIG_SERR_BIT] = sigSysErr_q;
		ssrValue[`PBW_SSR_PAR_DET_BIT]  = parDetected_q;
	end

	// window registers as read: the low nibble is hardwired
	wire pbw_half_t mmioBaseRd  = {mmioBase_q, `PBW_MMIO_LOW_NIBBLE};
	wire pbw_half_t mmioLimitRd = {mmioLimit_q, `PBW_MMIO_LOW_NIBBLE};
	wire pbw_half_t prefBaseRd  = {prefetchBase_q, `PBW_PREFETCH_LOW_NIBBLE};

	// bytes of these dwords owned by other banks read as zero here
	wire logic [31:0] rdWord = selSsr      ? {ssrValue, 16'h0000} :
	                           selMmio     ? {mmioLimitRd, mmioBaseRd} :
	                           selPrefetch ? {16'h0000, prefBaseRd} :
	                                         32'h00000000;

	// status flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dataParErr_q  <= 1'b0;
			sigTgtAbt_q   <= 1'b0;
			rcvTgtAbt_q   <= 1'b0;
			rcvMstAbt_q   <= 1'b0;
			sigSysErr_q   <= 1'b0;
			parDetected_q <= 1'b0;
		end else begin
			dataParErr_q  <= flagNext(dataParErr_q, parityErr & commandRegister,
				ssrClr[`PBW_SSR_DATA_PAR_BIT]);
			sigTgtAbt_q   <= flagNext(sigTgtAbt_q, sigTargetAbort,
				ssrClr[`PBW_SSR_SIG_TABT_BIT]);
			rcvTgtAbt_q   <= flagNext(rcvTgtAbt_q, rcvTargetAbort,
				ssrClr[`PBW_SSR_RCV_TABT_BIT]);
			rcvMstAbt_q   <= flagNext(rcvMstAbt_q, rcvMasterAbort,
				ssrClr[`PBW_SSR_RCV_MABT_BIT]);
			sigSysErr_q   <= flagNext(sigSysErr_q, systemErr,
				ssrClr[`PBW_SSR_SIG_SERR_BIT]);
			parDetected_q <= flagNext(parDetected_q, parityErr,
				ssrClr[`PBW_SSR_PAR_DET_BIT]);
		end
	end

	// window address fields; only bits 15:4 take write data
	wire logic wrMmio     = cfgWrite && selMmio;
	wire logic wrPrefetch = cfgWrite && selPrefetch;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mmioBase_q     <= `PBW_WIN_FIELD_RESET;
			mmioLimit_q    <= `PBW_WIN_FIELD_RESET;
			prefetchBase_q <= `PBW_WIN_FIELD_RESET;
		end else begin
			if (wrMmio) begin
				mmioBase_q  <= fieldWrite(mmioBase_q, lowData, lowMask);
				mmioLimit_q <= fieldWrite(mmioLimit_q, highData, highMask);
			end
			if (wrPrefetch) begin
				prefetchBase_q <= fieldWrite(prefetchBase_q, lowData, lowMask);
			end
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfgRdData  <= 32'h00000000;
			cfgRdValid <= 1'b0;
		end else begin
			cfgRdData  <= cfgRead ? rdWord : 32'h00000000;
			cfgRdValid <= cfgRead;
		end
	end

	// assembled windows; the memory window lives below 4 GB
	wire pbw_addr_t mmioBaseAddr  = {`PBW_MMIO_UPPER32, mmioBase_q, `PBW_BASE_LOW20};
	wire pbw_addr_t mmioLimitAddr = {`PBW_MMIO_UPPER32, mmioLimit_q, `PBW_LIMIT_LOW20};
	wire pbw_addr_t prefBaseAddr  = {prefetchBaseUpperWord, prefetchBase_q,
		`PBW_BASE_LOW20};
	wire pbw_addr_t prefLimitAddr = {prefetchLimitUpperWord,
		prefetchWindowLimit[`PBW_WIN_FIELD_MSB:`PBW_WIN_FIELD_LSB], `PBW_LIMIT_LOW20};

	logic mmioIn;
	logic prefetchIn;

	pbw_window_match u_mmio_match (
		.windowBase  (mmioBaseAddr),
		.windowLimit (mmioLimitAddr),
		.txnAddr     (txnAddr),
		.inWindow    (mmioIn)
	);

	pbw_window_match u_prefetch_match (
		.windowBase  (prefBaseAddr),
		.windowLimit (prefLimitAddr),
		.txnAddr     (txnAddr),
		.inWindow    (prefetchIn)
	);

	// hits are registered so the outputs come from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mmioHit     <= 1'b0;
			prefetchHit <= 1'b0;
		end else begin
			mmioHit     <= txnValid && mmioIn;
			prefetchHit <= txnValid && prefetchIn;
		end
	end

endmodule : pbw_bridge_regs

`default_nettype wire

/* verification/pbw_bridge_regs_assertions.sv */
// checker for the secondary status and window bank, top ports only.
// assumes one clock and active-low rst_n; bound to the bank below.
`timescale 1ns/1ps
`default_nettype none
module pbw_bridge_regs_assertions (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// configuration port
	input wire logic [7:0]  cfgAddr,
	input wire logic [3:0]  cfgByteEn,
	input wire logic        cfgWrite,
	input wire logic        cfgRead,
	input wire logic [31:0] cfgWrData,
	input wire logic [31:0] cfgRdData,
	// error sources
	input wire logic        commandRegister,
	input wire logic        secondaryParityErrorN,
	input wire logic        secondarySystemErrorN,
	input wire logic        sigTargetAbort,
	input wire logic        rcvTargetAbort,
	input wire logic        rcvMasterAbort
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic stRd  = cfgRead && cfgAddr[7:2] == 6'h07;
	wire logic memRd = cfgRead && cfgAddr[7:2] == 6'h08;
	wire logic pfRd  = cfgRead && cfgAddr[7:2] == 6'h09;
	wire logic clrWr = cfgWrite && cfgAddr[7:2] == 6'h07 && cfgByteEn[3] && cfgWrData[29];
	// pins pass two synchroniser flops before the flag sees them
	sequence serrHeld; !secondarySystemErrorN [*3]; endsequence
	sequence parHeld; !secondaryParityErrorN [*3]; endsequence
	sequence parResp; !secondaryParityErrorN [*2] ##1 (!secondaryParityErrorN && commandRegister);
	endsequence
	property abortSets(ev, int b); ev ##[1:4] stRd |=> cfgRdData[b]; endproperty
	status_fixed_a: assert property (stRd |=> cfgRdData[23:16] == 8'h20)
		else $error("status fixed low byte wrong");
	devsel_timing_a: assert property (stRd |=> cfgRdData[26:25] == 2'b01)
		else $error("status timing field wrong");
	mmio_nibble_a: assert property (memRd |=> cfgRdData[3:0] == 4'h0 && cfgRdData[19:16] == 4'h0)
		else $error("memory window nibble not zero");
	prefetch_nibble_a: assert property (pfRd |=> cfgRdData[3:0] == 4'h1)
		else $error("prefetch base nibble not one");
	sig_abort_a: assert property (abortSets(sigTargetAbort, 27))
		else $error("signalled target abort flag missing");
	rcv_abort_a: assert property (abortSets(rcvTargetAbort, 28))
		else $error("received target abort flag missing");
	mst_abort_a: assert property (abortSets(rcvMasterAbort, 29))
		else $error("received master abort flag missing");
	serr_flag_a: assert property (serrHeld ##[1:8] stRd |=> cfgRdData[30])
		else $error("system error flag missing");
	perr_flag_a: assert property (parHeld ##[1:8] stRd |=> cfgRdData[31])
		else $error("parity detected flag missing");
	perr_resp_a: assert property (parResp ##[1:8] stRd |=> cfgRdData[24])
		else $error("data parity flag missing");
	mabt_clear_a: assert property (clrWr && !rcvMasterAbort ##1 (!rcvMasterAbort throughout (##[0:3] stRd)) |=> !cfgRdData[29])
		else $error("master abort flag not cleared");
endmodule : pbw_bridge_regs_assertions
bind pbw_bridge_regs pbw_bridge_regs_assertions chk (.clk, .rst_n, .cfgAddr, .cfgByteEn, .cfgWrite,
	.cfgRead, .cfgWrData, .cfgRdData, .commandRegister, .secondaryParityErrorN,
	.secondarySystemErrorN, .sigTargetAbort, .rcvTargetAbort, .rcvMasterAbort);
`default_nettype wire

/* verification/pbw_sec_agent.sv */
// secondary bus agents: error pins and abort events towards the bank.
// assumes the bench calls its tasks; pins idle high as with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module pbw_sec_agent (
	// clock
	input  wire logic clk,
	// pins and events
	output var  logic perrN,
	output var  logic serrN,
	output var  logic sigTa,
	output var  logic rcvTa,
	output var  logic rcvMa
);
	initial {perrN, serrN, sigTa, rcvTa, rcvMa} = 5'h18;
	// bit 0 signalled target, bit 1 received target, bit 2 master abort
	task automatic pulse(input logic [2:0] which);
		@(posedge clk);
		{rcvMa, rcvTa, sigTa} <= which;
		@(posedge clk);
		{rcvMa, rcvTa, sigTa} <= 3'h0;
	endtask : pulse
	// held long enough to cross the synchroniser, then released to idle high
	task automatic pinLow(input logic [1:0] which, input int cycles);
		@(posedge clk);
		{serrN, perrN} <= ~which;
		repeat (cycles) @(posedge clk);
		{serrN, perrN} <= 2'h3;
	endtask : pinLow
endmodule : pbw_sec_agent
`default_nettype wire

/* verification/pbw_bridge_regs_tb.sv */
// self-checking bench for the status and window register bank.
// assumes the agent model drives the secondary pins and events.
`timescale 1ns/1ps
`default_nettype none
module pbw_bridge_regs_tb
	import pbw_pkg::*;
;
	typedef struct {
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic [31:0] rdExp;
		pbw_addr_t   txn;
		logic [1:0]  hits;
	} pbw_row_s;
	logic        clk, rst_n, cfgWrite, cfgRead, cfgRdValid, txnValid, mmioHit, prefetchHit;
	logic        commandRegister, secondaryParityErrorN, secondarySystemErrorN;
	logic        sigTargetAbort, rcvTargetAbort, rcvMasterAbort;
	logic [7:0]  cfgAddr;
	logic [3:0]  cfgByteEn;
	logic [31:0] cfgWrData, cfgRdData, rdData;
	logic [2:0]  rdFlags;
	pbw_addr_t   txnAddr;
	int          failCount, checksDone, cycleCount;
	// prefetch limit field 3ff with both upper words 1: 1_3000_0000 .. 1_3fff_ffff, from 1_0000_0000 once the base field is written zero
	pbw_row_s rows [8] = '{
		'{8'h20, 4'hf, 32'hffffffff, 32'hfff0fff0, 64'h0, 2'h0},
		'{8'h20, 4'h1, 32'h00000000, 32'hfff0ff00, 64'hffffffff, 2'h2},
		'{8'h20, 4'hf, 32'h1ff01000, 32'h1ff01000, 64'h10000000, 2'h2},
		'{8'h24, 4'h3, 32'hffff3000, 32'h00003001, 64'h130000000, 2'h1},
		'{8'h1c, 4'hf, 32'h00000000, 32'h02200000, 64'h1fffffff, 2'h2},
		'{8'h40, 4'hf, 32'hffffffff, 32'h00000000, 64'h20000000, 2'h0},
		'{8'h24, 4'hf, 32'h00000000, 32'h00000001, 64'h0fffffff, 2'h0},
		'{8'h28, 4'hf, 32'hffffffff, 32'h00000000, 64'h100000000, 2'h1}};
	pbw_bridge_regs uut (.clk, .rst_n, .cfgAddr, .cfgByteEn, .cfgWrite, .cfgRead, .cfgWrData,
		.cfgRdData, .cfgRdValid, .commandRegister, .secondaryParityErrorN,
		.secondarySystemErrorN, .sigTargetAbort, .rcvTargetAbort, .rcvMasterAbort,
		.prefetchWindowLimit(16'h3ff1), .prefetchBaseUpperWord(32'h1),
		.prefetchLimitUpperWord(32'h1), .txnValid, .txnAddr, .mmioHit, .prefetchHit);
	pbw_sec_agent agent (.clk, .perrN(secondaryParityErrorN), .serrN(secondarySystemErrorN),
		.sigTa(sigTargetAbort), .rcvTa(rcvTargetAbort), .rcvMa(rcvMasterAbort));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic closeOut;
		if (failCount == 0 && checksDone > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : closeOut
	always @(posedge clk) begin
		cycleCount <= cycleCount + 1;
		if (cycleCount == 3000) begin
			failCount++;
			closeOut();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfgWrite  <= 1'b1;
		cfgAddr   <= a;
		cfgByteEn <= be;
		cfgWrData <= d;
		@(posedge clk);
		cfgWrite  <= 1'b0;
	endtask : wr
	// read and window lookup share one request cycle
	task automatic rd(input logic [7:0] a, input pbw_addr_t t);
		@(posedge clk);
		cfgRead  <= 1'b1;
		cfgAddr  <= a;
		txnValid <= 1'b1;
		txnAddr  <= t;
		@(posedge clk);
		cfgRead  <= 1'b0;
		txnValid <= 1'b0;
		#1;
		rdData  = cfgRdData;
		rdFlags = {cfgRdValid, mmioHit, prefetchHit};
	endtask : rd
	task automatic st(input logic [15:0] e);
		rd(8'h1c, 64'h0);
		chk(rdData, {e, 16'h0000});
	endtask : st
	task automatic resetChk;
		st(16'h0220);
		rd(8'h20, 64'h0);
		chk(rdData, 32'h00000000);
		rd(8'h24, 64'h0);
		chk(rdData, 32'h00000001);
	endtask : resetChk
	initial begin
		{rst_n, cfgWrite, cfgRead, txnValid, commandRegister} = 5'h0;
		{cfgAddr, cfgByteEn, cfgWrData, txnAddr} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].be, rows[i].wdata);
			rd(rows[i].addr, rows[i].txn);
			chk(rdData, rows[i].rdExp);
			chk({29'h0, rdFlags}, {30'h1, rows[i].hits});
		end
		agent.pulse(3'h7);
		st(16'h3a20);
		wr(8'h1c, 4'hc, 32'h28000000);
		st(16'h1220);
		// event and clear in one cycle: the event must win
		fork
			agent.pulse(3'h2);
			wr(8'h1c, 4'hc, 32'h10000000);
		join
		st(16'h1220);
		agent.pinLow(2'h2, 4);
		repeat (3) @(posedge clk);
		st(16'h5220);
		agent.pinLow(2'h1, 4);
		repeat (3) @(posedge clk);
		st(16'hd220);
		@(posedge clk);
		commandRegister <= 1'b1;
		agent.pinLow(2'h1, 4);
		repeat (3) @(posedge clk);
		st(16'hd320);
		wr(8'h1c, 4'hc, 32'hffff0000);
		st(16'h0220);
		wr(8'h20, 4'hf, 32'h5550aaa0);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		resetChk();
		closeOut();
	end
endmodule : pbw_bridge_regs_tb
`default_nettype wire
